// File: verif/asu_remote.sv
// Remote serial station for the channel bench: makes the 1x bit clock,
// sends frames on the receive line, captures 8N1 frames from the line.
// Assumes 16 system clocks per bit and an idle-high line.
`timescale 1ns/10ps
module asu_remote (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic sclk_o,
  output logic rxd_o
);
  logic [2:0] cnt = 3'h0;
  logic fall = 1'b0;
  logic rise = 1'b0;
  logic [7:0] sh;
  logic [7:0] got_q[$];
  initial sclk_o = 1'b0;
  initial rxd_o = 1'b1;
  // ------------------------------------------------------------------
  // Bit clock, free running as a programmed clock does
  // ------------------------------------------------------------------
  always @(posedge clk_i) begin
    cnt <= cnt + 3'h1;
    fall <= (cnt == 3'h7) && sclk_o;
    rise <= (cnt == 3'h7) && !sclk_o;
    if (cnt == 3'h7) sclk_o <= !sclk_o;
  end
  // Bits change just after the falling edge, so they are mid-bit at rise
  task automatic send(input logic [11:0] bits);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i iff fall);
      rxd_o <= bits[i];
    end
  endtask : send
  // Capture on rising edges; a glitch of the line would be taken as data
  initial forever begin
    @(posedge clk_i iff (rise && txd_i === 1'b0));
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i iff rise);
      sh[i] = txd_i;
    end
    @(posedge clk_i iff rise);
    got_q.push_back(sh);
  end
endmodule : asu_remote

// File: verif/tb.sv
// Self-checking bench for the serial channel, driven over Wishbone.
// Assumes the remote station model and 1x clock mode throughout.
`timescale 1ns/10ps
module tb import asu_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic cts_n = 1'b0;
  logic [31:0] q;
  logic [31:0] rdat;
  logic [7:0] d[5];
  logic ack, sclk, rxd, txd, rts_n, irq;
  int errors = 0;
  int total_checks = 0;
  asu_channel dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sclk_i(sclk), .rx_serial_in_i(rxd), .clear_to_send_in_n_i(cts_n),
    .tx_serial_out_o(txd), .request_to_send_out_n_o(rts_n),
    .rx_int_o(irq));
  asu_remote p (.clk_i(clk_i), .txd_i(txd), .sclk_o(sclk), .rxd_o(rxd));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  initial forever #5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  // Classic cycle: hold until ack is sampled, then release one cycle
  task automatic wb(input logic w, input logic [4:0] a, input int v);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    req <= 1'b0;
    if (n >= 50) errors++;
  endtask : wb
  // Frame: start, n data bits LSB first, parity if p >= 0, then idle
  function automatic logic [11:0] frm(input logic [7:0] v, input int n,
                                      input int p);
    logic [11:0] f;
    f = 12'hFFE;
    for (int i = 0; i < n; i++) f[i+1] = v[i];
    if (p >= 0) f[n+1] = p[0];
    return f;
  endfunction : frm
  task automatic finish_test();
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    wt(60000);
    errors++;
    finish_test();
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    q = $urandom(32'h2ce5);
    wt(20);
    rst_i <= 1'b0;
    wb(0, ADR_MODE, 0);
    chk(q, 32'h0);
    wb(0, 5'h14, 0);
    chk(q, 32'h0);
    wb(1, ADR_MODE, 32'hC3);
    wb(1, ADR_CMD, 32'h65);
    // Two characters back to back through holding and shift registers
    for (int i = 0; i < 2; i++) begin
      d[i] = $urandom;
      wb(1, ADR_BUF, d[i]);
      wt(40);
    end
    for (int n = 0; n < 2000 && p.got_q.size() < 2; n++) wt(1);
    chk(p.got_q[0], d[0]);
    chk(p.got_q[1], d[1]);
    wt(40);
    wb(0, ADR_STAT, 0);
    chk(q[3:2], 2'h3);
    chk(txd, 1'b1);
    // Five characters into a three-deep buffer: the fourth is lost
    for (int i = 0; i < 5; i++) begin
      d[i] = $urandom;
      p.send(frm(d[i], 8, -1));
    end
    wt(40);
    wb(0, ADR_STAT, 0);
    chk(q[1:0], 2'h3);
    chk(q[4], 1'b1);
    chk(irq, 1'b1);
    chk(rts_n, 1'b1);
    wb(0, ADR_STAT, 0);
    chk(q[1:0], 2'h3);
    for (int i = 0; i < 4; i++) begin
      wb(0, ADR_BUF, 0);
      chk(q, {24'h0, d[i == 3 ? 4 : i]});
    end
    wb(0, ADR_STAT, 0);
    chk(q[0], 1'b0);
    chk(rts_n, 1'b0);
    // Seven bits, odd parity, block mode, second character corrupted
    wb(1, ADR_MODE, 32'h2E);
    for (int i = 0; i < 2; i++) begin
      d[i] = $urandom;
      p.send(frm(d[i], 7, int'(~^d[i][6:0] ^ i[0])));
    end
    wt(40);
    for (int i = 0; i < 2; i++) begin
      wb(0, ADR_STAT, 0);
      chk(q[5], i[0]);
      wb(0, ADR_BUF, 0);
      chk(q, {25'h0, d[i][6:0]});
    end
    // Block status outlives the buffer until a reset-error command
    wb(0, ADR_STAT, 0);
    chk(q[5], 1'b1);
    wb(1, ADR_CMD, 32'h30);
    wb(0, ADR_STAT, 0);
    chk(q[5], 1'b0);
    // Line low for longer than a character, then back high
    wb(1, ADR_MODE, 32'h3);
    p.send(12'h000);
    p.send(12'hFFF);
    wb(0, ADR_STAT, 0);
    chk({q[7], q[0]}, 2'h3);
    wb(0, ADR_BUF, 0);
    chk(q, 32'h0);
    wb(0, ADR_STAT, 0);
    chk(q[0], 1'b0);
    // Receiver reset empties the buffer and drops the request
    p.send(frm(d[0], 8, -1));
    wt(40);
    chk(irq, 1'b1);
    wb(1, ADR_CMD, 32'h10);
    wb(0, ADR_STAT, 0);
    chk({q[4], q[1:0]}, 3'h0);
    chk(irq, 1'b0);
    // Gating: break ignores the gate, characters wait for it
    wb(1, ADR_MODE, 32'h203);
    cts_n <= 1'b1;
    wb(1, ADR_CMD, 32'h40);
    wt(60);
    chk(txd, 1'b0);
    wb(1, ADR_CMD, 32'h50);
    wt(300);
    p.got_q.delete();
    d[0] = $urandom;
    wb(1, ADR_BUF, d[0]);
    wt(400);
    chk({p.got_q.size() == 0, txd}, 2'h3);
    cts_n <= 1'b0;
    for (int n = 0; n < 2000 && p.got_q.size() < 1; n++) wt(1);
    chk(p.got_q.pop_front(), d[0]);
    // Auto request-to-send: disable mid-character, line negates after
    wb(1, ADR_MODE, 32'h103);
    wb(1, ADR_CMD, 32'h60);
    d[1] = $urandom;
    wb(1, ADR_BUF, d[1]);
    wt(40);
    wb(1, ADR_CMD, 32'h08);
    for (int n = 0; n < 2000 && p.got_q.size() < 1; n++) wt(1);
    chk({rts_n, p.got_q[0]}, {1'b0, d[1]});
    wt(40);
    chk(rts_n, 1'b1);
    finish_test();
  end
endmodule : tb

// File: verilog/asu_channel.sv
// One asynchronous serial channel: transmitter, receiver, three-entry
// receive FIFO and a classic Wishbone register slave.
// Assumes sclk_i is the programmed bit clock (1x or 16x) from outside.
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module asu_channel import asu_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sclk_i,
  input wire logic rx_serial_in_i,
  input wire logic clear_to_send_in_n_i,
  output logic tx_serial_out_o,
  output logic request_to_send_out_n_o,
  output logic rx_int_o
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
                            TX_STOP} asu_tx_t;
  typedef enum logic [2:0] {RX_HUNT, RX_START, RX_DATA, RX_PAR, RX_STOP,
                            RX_MARK, RX_FEW} asu_rx_t;

  // Mask of valid data bits for a 5..8 bit character
  function automatic logic [7:0] len_mask(input logic [1:0] l);
    return 8'hFF >> (2'h3 - l);
  endfunction : len_mask

  // Even parity over the valid data bits
  function automatic logic par_of(input logic [7:0] d,
                                  input logic [1:0] l);
    return ^(d & len_mask(l));
  endfunction : par_of

  // ----------------------------------------------------------------------
  // Input synchronisers and bit clock edges
  // ----------------------------------------------------------------------
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic sclk_d;
  // Pins cross in through two flops; edges use only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      sclk_d <= 1'b1;
    end else if (ce_i) begin
      sync1 <= {sclk_i, rx_serial_in_i, clear_to_send_in_n_i};
      sync2 <= sync1;
      sclk_d <= sync2[2];
    end
  end
  wire sclk_rise = sync2[2] & ~sclk_d;
  wire sclk_fall = ~sync2[2] & sclk_d;
  wire rxd = sync2[1];
  wire cts_ok = ~sync2[0];

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic [10:0] mode;
  logic tx_en;
  logic rx_en;
  logic brk_on;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = wb_req & wb_we_i;
  wire rd = wb_req & ~wb_we_i;
  wire wr_mode = wr & (wb_adr_i == ADR_MODE);
  wire wr_cmd = wr & wb_sel_i[0] & (wb_adr_i == ADR_CMD);
  wire wr_buf = wr & wb_sel_i[0] & (wb_adr_i == ADR_BUF);
  wire rd_buf = rd & (wb_adr_i == ADR_BUF);
  wire rd_stat = rd & (wb_adr_i == ADR_STAT);
  wire [1:0] cmd_rx = wr_cmd ? wb_dat_i[CB_RX +: 2] : 2'h0;
  wire [1:0] cmd_tx = wr_cmd ? wb_dat_i[CB_TX +: 2] : 2'h0;
  wire [2:0] cmd_mc = wr_cmd ? wb_dat_i[CB_MISC +: 3] : 3'h0;
  wire rst_rx = (cmd_mc == MC_RST_RX);
  wire rst_tx = (cmd_mc == MC_RST_TX);
  wire [1:0] len = mode[MB_LEN +: 2];
  wire x16 = mode[MB_X16];

  // Mode register, byte lanes 0 and 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= MODE_RST;
    end else if (ce_i && wr_mode) begin
      if (wb_sel_i[0]) mode[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) mode[10:8] <= wb_dat_i[10:8];
    end
  end

  // Enables and break; a reset command also disables its half
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_en <= 1'b0;
      rx_en <= 1'b0;
      brk_on <= 1'b0;
    end else if (ce_i) begin
      if (cmd_tx == CMD_EN) tx_en <= 1'b1;
      if (cmd_tx == CMD_DIS || rst_tx) tx_en <= 1'b0;
      if (cmd_rx == CMD_EN) rx_en <= 1'b1;
      if (cmd_rx == CMD_DIS || rst_rx) rx_en <= 1'b0;
      if (cmd_mc == MC_BRK_ON) brk_on <= 1'b1;
      if (cmd_mc == MC_BRK_OFF || rst_tx) brk_on <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  asu_tx_t tx_st;
  logic [7:0] thr;
  logic thr_full;
  logic [7:0] tx_sr;
  logic [2:0] tx_cnt;
  logic tx_stop2nd;
  logic [3:0] tx_div;
  logic tx_bit;
  logic tx_empty;
  logic rts_wait;
  logic [7:0] thr_sent;
  wire tx_tick = sclk_fall & (~x16 | (tx_div == X16_LAST));
  // Break owns the line, so clear-to-send is not even looked at
  wire tx_load = tx_tick & (tx_st == TX_IDLE) & thr_full & tx_en &
                 ~brk_on & (~mode[MB_CTSEN] | cts_ok);
  wire tx_last = (tx_cnt == {1'b1, len});
  wire tx_done = tx_tick & (tx_st == TX_STOP) &
                 (~mode[MB_STOP2] | tx_stop2nd);
  wire tx_ready = tx_en & ~thr_full;

  // Holding register and empty flag; the set wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && rst_tx)) begin
      thr_full <= 1'b0;
      thr <= 8'h00;
      tx_empty <= 1'b1;
    end else if (ce_i) begin
      if (wr_buf) begin
        thr <= wb_dat_i[7:0];
        thr_full <= 1'b1;
        tx_empty <= 1'b0;
      end else if (tx_load) begin
        thr_full <= 1'b0;
      end
      if (tx_done && !thr_full) tx_empty <= 1'b1;
    end
  end

  // Divider for the 16x bit clock
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && rst_tx)) tx_div <= 4'h0;
    else if (ce_i && sclk_fall) tx_div <= tx_div + 4'h1;
  end

  // Frame shifter; only changes on falling bit clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && rst_tx)) begin
      tx_st <= TX_IDLE;
      tx_bit <= 1'b1;
      tx_sr <= 8'h00;
      tx_cnt <= 3'h0;
      tx_stop2nd <= 1'b0;
    end else if (ce_i && tx_tick) begin
      unique case (tx_st)
        TX_IDLE: begin
          tx_bit <= ~tx_load;
          if (tx_load) begin
            tx_st <= TX_START;
            tx_sr <= thr;
          end
        end
        TX_START: begin
          tx_st <= TX_DATA;
          tx_bit <= tx_sr[0];
          tx_cnt <= 3'h0;
        end
        TX_DATA: begin
          tx_cnt <= tx_cnt + 3'h1;
          tx_sr <= {1'b0, tx_sr[7:1]};
          if (!tx_last) begin
            tx_bit <= tx_sr[1];
          end else if (mode[MB_PEN]) begin
            tx_st <= TX_PAR;
            tx_bit <= par_of(thr_sent, len) ^ mode[MB_PODD];
          end else begin
            tx_st <= TX_STOP;
            tx_bit <= 1'b1;
          end
        end
        TX_PAR: begin
          tx_st <= TX_STOP;
          tx_bit <= 1'b1;
        end
        TX_STOP: begin
          tx_stop2nd <= ~tx_done;
          if (tx_done) tx_st <= TX_IDLE;
        end
      endcase
    end
  end

  // Copy of the character in flight, for its parity bit
  always_ff @(posedge clk_i) begin
    if (rst_i) thr_sent <= 8'h00;
    else if (ce_i && tx_load) thr_sent <= thr;
  end

  // Line driver; break forces space regardless of frame state
  always_ff @(posedge clk_i) begin
    if (rst_i) tx_serial_out_o <= 1'b1;
    else if (ce_i) tx_serial_out_o <= tx_bit & ~brk_on;
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  asu_rx_t rx_st;
  logic [3:0] rx_sc;
  logic [7:0] rsr;
  logic [2:0] rx_cnt;
  logic rx_zero;
  logic rx_pbit;
  logic [10:0] pend;
  logic pend_v;
  logic [1:0] cnt;
  wire [3:0] rx_lim = (rx_st == RX_DATA || rx_st == RX_PAR ||
                       rx_st == RX_STOP) ? X16_LAST : X16_HALF;
  wire smp = sclk_rise & (~x16 | (rx_sc == rx_lim));
  wire pop = rd_buf & (cnt != 2'h0);
  wire fifo_full = (cnt == FIFO_FULL);
  wire start_ok = smp & (rx_st == RX_START) & ~rxd;
  wire ovr_ev = start_ok & pend_v & fifo_full & ~pop;
  wire push = pend_v & (~fifo_full | pop);
  wire [7:0] rx_data = rsr >> (2'h3 - len);
  wire rx_fe = ~rxd;
  wire rx_brk = rx_fe & rx_zero;
  wire rx_pe = mode[MB_PEN] &
               ((par_of(rx_data, len) ^ rx_pbit) != mode[MB_PODD]);

  // Sample counter; in the mark wait any low level restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && rst_rx)) rx_sc <= 4'h0;
    else if (ce_i && sclk_rise) begin
      if (rx_st == RX_HUNT || smp || (rx_st == RX_MARK && !rxd))
        rx_sc <= 4'h0;
      else
        rx_sc <= rx_sc + 4'h1;
    end
  end

  // Character assembly; entries queue in pend when the FIFO is full
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && rst_rx)) begin
      rx_st <= RX_HUNT;
      rsr <= 8'h00;
      rx_cnt <= 3'h0;
      rx_zero <= 1'b1;
      rx_pbit <= 1'b0;
      pend <= 11'h000;
      pend_v <= 1'b0;
    end else if (ce_i) begin
      if (push || ovr_ev) pend_v <= 1'b0;
      unique case (rx_st)
        // In 1x mode the fall is seen on the system clock, so the next
        // rising bit clock edge is the resample, not a data bit
        RX_HUNT: if ((sclk_rise || !x16) && rx_en && !rxd)
          rx_st <= RX_START;
        RX_START: if (smp) begin
          rx_st <= rxd ? RX_HUNT : RX_DATA;
          rx_cnt <= 3'h0;
          rx_zero <= 1'b1;
        end
        RX_DATA: if (smp) begin
          rsr <= {rxd, rsr[7:1]};
          rx_zero <= rx_zero & ~rxd;
          rx_cnt <= rx_cnt + 3'h1;
          if (rx_cnt == {1'b1, len})
            rx_st <= mode[MB_PEN] ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (smp) begin
          rx_pbit <= rxd;
          rx_zero <= rx_zero & ~rxd;
          rx_st <= RX_STOP;
        end
        RX_STOP: if (smp) begin
          pend <= {rx_brk, rx_fe, rx_pe & ~rx_brk,
                   rx_brk ? 8'h00 : rx_data};
          pend_v <= 1'b1;
          rx_st <= rx_brk ? RX_MARK : (rx_fe ? RX_FEW : RX_HUNT);
        end
        RX_MARK: if (smp && rxd) rx_st <= RX_HUNT;
        RX_FEW: if (smp) rx_st <= rxd ? RX_HUNT : RX_START;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receive FIFO and status
  // ----------------------------------------------------------------------
  logic [10:0] fifo [3];
  logic [1:0] rd_p;
  logic [1:0] wr_p;
  logic ovr;
  logic [2:0] acc;
  logic head_new;
  wire [10:0] head = fifo[rd_p];
  wire rx_ready = (cnt != 2'h0);
  wire [2:0] err = mode[MB_BLOCK] ? acc : head[EN_BRK:EN_PE];
  wire rst_err = (cmd_mc == MC_RST_ERR);

  // Three entries behind the shifter; push and pop may coincide
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && rst_rx)) begin
      rd_p <= 2'h0;
      wr_p <= 2'h0;
      cnt <= 2'h0;
    end else if (ce_i) begin
      if (push) wr_p <= (wr_p == FIFO_LAST) ? 2'h0 : wr_p + 2'h1;
      if (pop) rd_p <= (rd_p == FIFO_LAST) ? 2'h0 : rd_p + 2'h1;
      if (push && !pop) cnt <= cnt + 2'h1;
      else if (pop && !push) cnt <= cnt - 2'h1;
    end
  end

  // Entry storage, no reset: cnt guards the data and block reads, not the status error bits outside block mode
  always_ff @(posedge clk_i) begin
    if (ce_i && push) fifo[wr_p] <= pend;
  end

  // Overrun and block accumulator; a new event beats the reset-error clear, but a receiver reset wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr <= 1'b0;
      acc <= 3'h0;
      head_new <= 1'b0;
    end else if (ce_i) begin
      head_new <= (pop & (cnt > 2'h1)) |
                  (push & ((cnt == 2'h0) | (pop & (cnt == 2'h1))));
      if (rst_err || rst_rx) begin
        ovr <= 1'b0;
        acc <= 3'h0;
      end
      if (ovr_ev && !rst_rx) ovr <= 1'b1;
      if (head_new && rx_ready && !rst_rx)
        acc <= (rst_err ? 3'h0 : acc) | head[EN_BRK:EN_PE];
    end
  end

  // ----------------------------------------------------------------------
  // Request-to-send: software, receiver flow and transmitter auto modes
  // ----------------------------------------------------------------------
  logic flow_held;
  wire flow_neg = mode[MB_RXRTS] & start_ok & fifo_full;
  wire flow_pos = mode[MB_RXRTS] & flow_held & ~fifo_full;
  wire auto_neg = rts_wait & tx_tick;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      request_to_send_out_n_o <= 1'b1;
      flow_held <= 1'b0;
      rts_wait <= 1'b0;
    end else if (ce_i) begin
      if (cmd_mc == MC_RTS_ON || flow_pos)
        request_to_send_out_n_o <= 1'b0;
      if (cmd_mc == MC_RTS_OFF || flow_neg || auto_neg)
        request_to_send_out_n_o <= 1'b1;
      if (flow_neg) flow_held <= 1'b1;
      else if (flow_pos || rst_rx) flow_held <= 1'b0;
      if (tx_done && mode[MB_TXRTS] && !tx_en) rts_wait <= 1'b1;
      else if (auto_neg || rst_tx) rts_wait <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read data, acknowledge and receive request
  // ----------------------------------------------------------------------
  // Status: brk fe pe ovr tx_empty_flag tx_ready_flag fifo_full_flag rx_ready_flag, bit 7 down to 0
  wire [7:0] stat = {err, ovr, tx_empty, tx_ready, fifo_full, rx_ready};
  wire [31:0] rdata = (wb_adr_i == ADR_MODE) ? {21'h0, mode} :
                      (wb_adr_i == ADR_STAT) ? {24'h0, stat} :
                      (wb_adr_i == ADR_BUF && rx_ready) ?
                      {24'h0, head[7:0]} : 32'h0;
  // One wait state; unmapped or write-only addresses read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      rx_int_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (rd) wb_dat_o <= rdata;
      rx_int_o <= mode[MB_FFIRQ] ? fifo_full : rx_ready;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tx_ready_flag_drop: assert property (ce_i && wr_buf && !rst_tx |=>
    !stat[2]) else $error("tx ready stayed set after load");
  a_start_space: assert property (ce_i && tx_load |=>
    ##1 (!tx_serial_out_o || !ce_i)) else $error("no start bit");
  a_idle_mark: assert property (tx_st == TX_IDLE && !brk_on &&
    !tx_load && ce_i && $past(tx_st) == TX_IDLE |=> tx_serial_out_o)
    else $error("idle line not at mark");
  a_txrst_stop: assert property (ce_i && rst_tx |=>
    tx_st == TX_IDLE && !tx_en) else $error("tx reset ignored");
  a_cts_gate: assert property (tx_load |->
    !mode[MB_CTSEN] || cts_ok) else $error("start without cts");
  a_break_low: assert property (ce_i && brk_on |=>
    !tx_serial_out_o) else $error("break not driving space");
  a_rx_upper_zero: assert property (pend_v |->
    (pend[7:0] & ~len_mask(len)) == 8'h00 || $changed(mode))
    else $error("unused data bits set");
  a_fifo_bound: assert property (wr_p <= FIFO_LAST &&
    rd_p <= FIFO_LAST && ((wr_p == rd_p) == (cnt == 2'h0 || fifo_full)))
    else $error("fifo count out of range");
  a_rx_ready_flag_clear: assert property (ce_i && pop && cnt == 2'h1 &&
    !push |=> !rx_ready) else $error("ready after last pop");
  a_stat_no_pop: assert property (ce_i && rd_stat && !push &&
    !rst_rx |=> cnt == $past(cnt)) else $error("status read popped");
  a_overrun_set: assert property (ce_i && ovr_ev |=> ovr &&
    !pend_v) else $error("overrun not flagged");
  a_rxrst_clear: assert property (ce_i && rst_rx |=> cnt == 2'h0 &&
    !ovr && rx_st == RX_HUNT) else $error("rx reset incomplete");

  c_tx_frame: cover property (tx_done ##[1:40] tx_load);
  c_rx_break: cover property (push && pend[EN_BRK]);
  c_overrun: cover property (ovr_ev);
  c_fifo_full: cover property (fifo_full && pend_v);
endmodule : asu_channel

// File: verilog/asu_pkg.sv
// Constants shared by the serial channel: register map, field positions,
// command codes and sampling counts.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package asu_pkg;
  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADR_MODE = 5'h00;
  localparam logic [4:0] ADR_STAT = 5'h04;
  localparam logic [4:0] ADR_CMD = 5'h08;
  localparam logic [4:0] ADR_BUF = 5'h0C;
  // ----------------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------------
  localparam int MB_LEN = 0;
  localparam int MB_PEN = 2;
  localparam int MB_PODD = 3;
  localparam int MB_STOP2 = 4;
  localparam int MB_BLOCK = 5;
  localparam int MB_FFIRQ = 6;
  localparam int MB_RXRTS = 7;
  localparam int MB_TXRTS = 8;
  localparam int MB_CTSEN = 9;
  localparam int MB_X16 = 10;
  localparam int MODE_W = 11;
  localparam logic [10:0] MODE_RST = 11'h000;
  // ----------------------------------------------------------------------
  // Command register fields and codes
  // ----------------------------------------------------------------------
  localparam int CB_RX = 0;
  localparam int CB_TX = 2;
  localparam int CB_MISC = 4;
  localparam logic [1:0] CMD_EN = 2'h1;
  localparam logic [1:0] CMD_DIS = 2'h2;
  localparam logic [2:0] MC_RST_RX = 3'h1;
  localparam logic [2:0] MC_RST_TX = 3'h2;
  localparam logic [2:0] MC_RST_ERR = 3'h3;
  localparam logic [2:0] MC_BRK_ON = 3'h4;
  localparam logic [2:0] MC_BRK_OFF = 3'h5;
  localparam logic [2:0] MC_RTS_ON = 3'h6;
  localparam logic [2:0] MC_RTS_OFF = 3'h7;
  // ----------------------------------------------------------------------
  // Receive entry layout, FIFO and sampling counts
  // ----------------------------------------------------------------------
  localparam int EN_PE = 8;
  localparam int EN_FE = 9;
  localparam int EN_BRK = 10;
  localparam logic [1:0] FIFO_LAST = 2'h2;
  localparam logic [1:0] FIFO_FULL = 2'h3;
  localparam logic [3:0] X16_HALF = 4'h7;
  localparam logic [3:0] X16_LAST = 4'hF;
endpackage : asu_pkg
